// ### sap_pkg.sv
// Constants shared by the serial audio input port: register map, field layout,
// format and rate codes, and the timing figures of the halt detector.
// Assumes a 50 MHz system clock; all cycle counts derive from CLK_HZ.
package sap_pkg;

  // Register addresses.
  localparam logic [7:0] ADDR_FORMAT     = 8'h33;
  localparam logic [7:0] ADDR_OFFSET_LOW = 8'h34;
  localparam logic [7:0] ADDR_STATUS     = 8'h71;

  // Reset values: I2S framing with a 24-bit word, zero offset.
  localparam logic [7:0] FORMAT_RESET    = 8'h02;
  localparam logic [7:0] OFFSET_RESET    = 8'h00;

  // Field positions inside the format register.
  localparam int WLEN_LSB       = 0;
  localparam int SYNC_LSB       = 2;
  localparam int FMT_LSB        = 4;
  localparam int OFFSET_MSB_BIT = 7;

  // Field positions inside the status register.
  localparam int STAT_ERR_BIT   = 0;
  localparam int STAT_HALT_BIT  = 1;
  localparam int STAT_RATE_LSB  = 2;

  // Audio format codes.
  localparam logic [1:0] FMT_I2S = 2'h0;
  localparam logic [1:0] FMT_LJ  = 2'h1;
  localparam logic [1:0] FMT_RJ  = 2'h2;
  localparam logic [1:0] FMT_TDM = 2'h3;

  // Word length codes and their widths in bits.
  localparam logic [1:0] WLEN_16 = 2'h0;
  localparam logic [1:0] WLEN_20 = 2'h1;
  localparam logic [1:0] WLEN_24 = 2'h2;
  localparam logic [1:0] WLEN_32 = 2'h3;
  localparam logic [9:0] BITS_16 = 10'h010;
  localparam logic [9:0] BITS_20 = 10'h014;
  localparam logic [9:0] BITS_24 = 10'h018;
  localparam logic [9:0] BITS_32 = 10'h020;

  // Bit clocks per frame that the port accepts.
  localparam logic [9:0] RATIO_32  = 10'h020;
  localparam logic [9:0] RATIO_64  = 10'h040;
  localparam logic [9:0] RATIO_128 = 10'h080;
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_512 = 10'h200;

  // Detected sample rate classes.
  localparam logic [1:0] RATE_32K = 2'h0;
  localparam logic [1:0] RATE_48K = 2'h1;
  localparam logic [1:0] RATE_96K = 2'h2;

  // Sample word and TDM slot geometry.
  localparam int WORD_BITS     = 32;
  localparam int TDM_SLOT_BITS = 32;
  localparam int CNT_W         = 10;

  // System clock and halt timeout.
  localparam int CLK_HZ       = 50_000_000;
  // The timeout must outlast the longest frame-clock level, about 31 us for
  // 32 kHz TDM with a one-bit sync pulse. It must also stay well under the
  // 100 us that a host gives for a rate change, or that halt goes unseen.
  localparam int HALT_TIME_NS = 50_000;
  localparam int HALT_CYCLES  = HALT_TIME_NS / (1_000_000_000 / CLK_HZ);

  // Rate class boundaries, as least frame periods in system cycles.
  localparam int RATE_EDGE_LOW_HZ  = 40_000;
  localparam int RATE_EDGE_HIGH_HZ = 72_000;
  localparam logic [15:0] PERIOD_32K_MIN = 16'(CLK_HZ / RATE_EDGE_LOW_HZ);
  localparam logic [15:0] PERIOD_48K_MIN = 16'(CLK_HZ / RATE_EDGE_HIGH_HZ);

  // Good frames needed before a halt is lifted.
  localparam int RECOVER_FRAMES = 2;

endpackage

// ### sap_sync.sv
// Two-flop synchroniser for levels and toggles entering a clock domain.
// Assumes each bit crosses on its own; buses must be quasi-static.
`timescale 1ns/1ps
module sap_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ### serial_audio_input_port.sv
// Serial audio input port: receives I2S, left-justified, right-justified and TDM
// frames on the bit clock, checks the clock ratio and detects halts.
// Assumes the host drives frame clock and data from the bit clock it supplies.
`timescale 1ns/1ps
module serial_audio_input_port #(
  parameter int HALT_CYCLES    = sap_pkg::HALT_CYCLES,
  parameter int RECOVER_FRAMES = sap_pkg::RECOVER_FRAMES
) (
  // System clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // Serial audio link
  input  wire logic        BIT_CLK,
  input  wire logic        FRAME_CLK,
  input  wire logic        SERIAL_DATA,
  // Register access
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  // Amplifier mode
  input  wire logic        PARALLEL_OUTPUT_MODE,
  // Received samples
  output logic      [31:0] SAMPLE_LEFT,
  output logic      [31:0] SAMPLE_RIGHT,
  output logic             SAMPLE_VALID,
  // Status
  output logic             OUT_HIZ,
  output logic             CLOCK_ERROR,
  output logic      [1:0]  RATE_CLASS
);

  localparam int W  = sap_pkg::WORD_BITS;
  localparam int CW = sap_pkg::CNT_W;

  // System domain registers.
  logic [7:0]    format_reg;
  logic [7:0]    offset_low_reg;
  logic          halt_reg;
  logic          ratio_err_reg;
  logic          first_reg;
  logic [1:0]    rate_reg;
  logic [15:0]   period_reg;
  logic [7:0]    good_reg;
  logic [2:0]    pin_s;
  logic [2:0]    pin_d;
  logic [1:0]    idle_hit;

  // Link domain registers.
  logic [12:0]   cfg_link;
  logic          fs_q;
  logic          sd_q;
  logic          fs_prev;
  logic [CW-1:0] bit_cnt;
  logic [CW-1:0] frame_cnt;
  logic [CW-1:0] half_len;
  logic [W-1:0]  acc;
  logic [W-1:0]  left_word;
  logic [W-1:0]  right_word;
  logic [W-1:0]  left_hold;
  logic [W-1:0]  right_hold;
  logic [CW-1:0] bits_hold;
  logic          evt_tgl;

  // Word length code to bits.
  function automatic logic [CW-1:0] wl_bits(input logic [1:0] code);
    unique case (code)
      sap_pkg::WLEN_16: wl_bits = sap_pkg::BITS_16;
      sap_pkg::WLEN_20: wl_bits = sap_pkg::BITS_20;
      sap_pkg::WLEN_24: wl_bits = sap_pkg::BITS_24;
      sap_pkg::WLEN_32: wl_bits = sap_pkg::BITS_32;
    endcase
  endfunction

  // Accepted bit clocks per frame for a format and rate class.
  function automatic logic ratio_supported(input logic [1:0] fmt, input logic [1:0] rate,
                                           input logic [CW-1:0] bits);
    if (fmt != sap_pkg::FMT_TDM) begin
      ratio_supported = (bits == sap_pkg::RATIO_32) || (bits == sap_pkg::RATIO_64);
    end else if (rate == sap_pkg::RATE_32K) begin
      ratio_supported = (bits == sap_pkg::RATIO_128);
    end else if (rate == sap_pkg::RATE_48K) begin
      ratio_supported = (bits == sap_pkg::RATIO_128) || (bits == sap_pkg::RATIO_256) ||
                        (bits == sap_pkg::RATIO_512);
    end else begin
      ratio_supported = (bits == sap_pkg::RATIO_128) || (bits == sap_pkg::RATIO_256);
    end
  endfunction

  // Configuration crosses into the link domain as a quasi-static bus.
  // Software should change it only while clocks are halted, so bits never skew within a frame.
  sap_sync #(.WIDTH(13)) cfg_sync (
    .clk (BIT_CLK),
    .rst (SYS_RST),
    .d   ({format_reg[sap_pkg::OFFSET_MSB_BIT], offset_low_reg,
           format_reg[sap_pkg::FMT_LSB +: 2], format_reg[sap_pkg::WLEN_LSB +: 2]}),
    .q   (cfg_link)
  );

  logic [1:0]    l_fmt;
  logic [CW-1:0] l_wl;
  logic [CW-1:0] l_off;
  logic          half_start;
  logic          rising;
  logic          seg_start;
  logic [CW-1:0] pos;
  logic          chan_left;
  logic          frame_start;
  logic [CW-1:0] slot_base;
  logic          in_win;
  logic          last_bit;
  logic [W-1:0]  acc_next;
  logic [W-1:0]  justified;

  // Frame decode: where the segment starts, which channel, which bits to take.
  always_comb begin
    l_fmt      = cfg_link[3:2];
    l_wl       = wl_bits(cfg_link[1:0]);
    l_off      = {1'b0, cfg_link[12:4]};
    half_start = fs_q ^ fs_prev;
    rising     = fs_q & ~fs_prev;
    seg_start  = (l_fmt == sap_pkg::FMT_TDM) ? rising : half_start;
    pos        = seg_start ? '0 : bit_cnt;
    unique case (l_fmt)
      sap_pkg::FMT_I2S: chan_left = ~fs_q;
      sap_pkg::FMT_TDM: chan_left = pos < CW'(l_off + CW'(sap_pkg::TDM_SLOT_BITS));
      default:          chan_left = fs_q;
    endcase
    frame_start = (l_fmt == sap_pkg::FMT_TDM) ? rising : (half_start & chan_left);
    unique case (l_fmt)
      sap_pkg::FMT_I2S: slot_base = CW'(l_off + 10'h001);
      sap_pkg::FMT_LJ:  slot_base = l_off;
      sap_pkg::FMT_RJ:  slot_base = (half_len > l_wl) ? CW'(half_len - l_wl) : '0;
      sap_pkg::FMT_TDM: slot_base = chan_left ? l_off : CW'(l_off + CW'(sap_pkg::TDM_SLOT_BITS));
    endcase
    in_win    = (pos >= slot_base) && (pos < CW'(slot_base + l_wl));
    last_bit  = (pos == CW'(slot_base + l_wl - 10'h001));
    acc_next  = {acc[W-2:0], sd_q};
    justified = acc_next << (CW'(W) - l_wl);
  end

  // Pin capture on the bit clock rising edge.
  always_ff @(posedge BIT_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fs_q    <= 1'b0;
      sd_q    <= 1'b0;
      fs_prev <= 1'b0;
    end else begin
      fs_q    <= FRAME_CLK;
      sd_q    <= SERIAL_DATA;
      fs_prev <= fs_q;
    end
  end

  // Bit position counters; they saturate so an over-long frame cannot alias a short one.
  always_ff @(posedge BIT_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bit_cnt   <= '0;
      frame_cnt <= '0;
      half_len  <= '0;
    end else begin
      bit_cnt   <= (pos == '1) ? pos : CW'(pos + 10'h001);
      frame_cnt <= frame_start ? 10'h001 : ((frame_cnt == '1) ? frame_cnt : CW'(frame_cnt + 10'h001));
      if (seg_start) begin
        half_len <= bit_cnt;
      end
    end
  end

  // Serial to parallel: the word is left-justified so its sign stays in bit 31.
  always_ff @(posedge BIT_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      acc        <= '0;
      left_word  <= '0;
      right_word <= '0;
    end else begin
      if (in_win) begin
        acc <= acc_next;
      end
      if (in_win && last_bit && chan_left) begin
        left_word <= justified;
      end
      if (in_win && last_bit && !chan_left) begin
        right_word <= justified;
      end
    end
  end

  // Frame event: hold words and ratio stable for a whole frame, then toggle.
  // The hold time is far longer than the two-flop delay, so the data crossing is safe.
  always_ff @(posedge BIT_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      left_hold  <= '0;
      right_hold <= '0;
      bits_hold  <= '0;
      evt_tgl    <= 1'b0;
    end else if (frame_start) begin
      left_hold  <= left_word;
      right_hold <= right_word;
      bits_hold  <= frame_cnt;
      evt_tgl    <= ~evt_tgl;
    end
  end

  // Pins and the event toggle enter the system domain through two flops each.
  sap_sync #(.WIDTH(3)) pin_sync (
    .clk (CLOCK),
    .rst (SYS_RST),
    .d   ({evt_tgl, FRAME_CLK, BIT_CLK}),
    .q   (pin_s)
  );

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_d <= '0;
    end else begin
      pin_d <= pin_s;
    end
  end

  logic frame_evt;
  logic ratio_ok;
  logic [1:0] rate_next;
  logic halt_set;
  logic halt_clr;

  // One idle timer per clock pin; an edge on that pin restarts it.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_idle
      logic [12:0] idle_reg;
      always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
          idle_reg <= '0;
        end else if (pin_s[gi] ^ pin_d[gi]) begin
          idle_reg <= '0;
        end else if (idle_reg != 13'(HALT_CYCLES)) begin
          idle_reg <= idle_reg + 13'h0001;
        end
      end
      assign idle_hit[gi] = (idle_reg == 13'(HALT_CYCLES - 1)) && !(pin_s[gi] ^ pin_d[gi]);
    end
  endgenerate

  // Rate class from the frame period, and the ratio check against it.
  always_comb begin
    frame_evt = pin_s[2] ^ pin_d[2];
    if (period_reg >= sap_pkg::PERIOD_32K_MIN) begin
      rate_next = sap_pkg::RATE_32K;
    end else if (period_reg >= sap_pkg::PERIOD_48K_MIN) begin
      rate_next = sap_pkg::RATE_48K;
    end else begin
      rate_next = sap_pkg::RATE_96K;
    end
    ratio_ok = ratio_supported(format_reg[sap_pkg::FMT_LSB +: 2], rate_next, bits_hold);
    halt_set = |idle_hit;
    halt_clr = halt_reg && frame_evt && !first_reg && ratio_ok && (good_reg == 8'(RECOVER_FRAMES - 1));
  end

  // Frame period and detected rate.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      period_reg <= '0;
      rate_reg   <= sap_pkg::RATE_48K;
    end else begin
      if (frame_evt) begin
        period_reg <= 16'h0001;
      end else if (period_reg != '1) begin
        period_reg <= period_reg + 16'h0001;
      end
      if (frame_evt && !first_reg) begin
        rate_reg <= rate_next;
      end
    end
  end

  // Halt state: set wins over clear. The first frame after a halt is only a timing
  // reference, because its length and period straddle the gap.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      halt_reg  <= 1'b1;
      first_reg <= 1'b1;
      good_reg  <= '0;
    end else begin
      if (halt_set) begin
        halt_reg  <= 1'b1;
        first_reg <= 1'b1;
        good_reg  <= '0;
      end else if (frame_evt) begin
        first_reg <= 1'b0;
        if (halt_clr) begin
          halt_reg <= 1'b0;
          good_reg <= '0;
        end else if (halt_reg && !first_reg) begin
          good_reg <= ratio_ok ? good_reg + 8'h01 : 8'h00;
        end
      end
    end
  end

  // Ratio error is judged once per complete frame.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ratio_err_reg <= 1'b0;
    end else if (frame_evt && !first_reg) begin
      ratio_err_reg <= !ratio_ok;
    end
  end

  // Sample delivery; halted frames are dropped. Mono mode feeds left to both outputs.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SAMPLE_LEFT  <= '0;
      SAMPLE_RIGHT <= '0;
      SAMPLE_VALID <= 1'b0;
    end else begin
      SAMPLE_VALID <= frame_evt && !halt_reg && !halt_set;
      if (frame_evt && !halt_reg && !halt_set) begin
        SAMPLE_LEFT  <= left_hold;
        SAMPLE_RIGHT <= PARALLEL_OUTPUT_MODE ? left_hold : right_hold;
      end
    end
  end

  // Configuration registers. Bits 3:2 are stored for software; the decoder does not
  // depend on them because it finds the sync edge regardless of its width.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      format_reg     <= sap_pkg::FORMAT_RESET;
      offset_low_reg <= sap_pkg::OFFSET_RESET;
    end else if (REG_WR) begin
      if (REG_ADDR == sap_pkg::ADDR_FORMAT) begin
        format_reg <= REG_WDATA;
      end
      if (REG_ADDR == sap_pkg::ADDR_OFFSET_LOW) begin
        offset_low_reg <= REG_WDATA;
      end
    end
  end

  // Register read: data one cycle after the strobe, zero for unmapped addresses.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        sap_pkg::ADDR_FORMAT:     REG_RDATA <= format_reg;
        sap_pkg::ADDR_OFFSET_LOW: REG_RDATA <= offset_low_reg;
        sap_pkg::ADDR_STATUS: begin
          REG_RDATA <= '0;
          REG_RDATA[sap_pkg::STAT_ERR_BIT]        <= halt_reg | ratio_err_reg;
          REG_RDATA[sap_pkg::STAT_HALT_BIT]       <= halt_reg;
          REG_RDATA[sap_pkg::STAT_RATE_LSB +: 2]  <= rate_reg;
        end
        default:                  REG_RDATA <= '0;
      endcase
    end
  end

  // Status outputs.
  assign OUT_HIZ     = halt_reg;
  assign CLOCK_ERROR = halt_reg | ratio_err_reg;
  assign RATE_CLASS  = rate_reg;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  halt_timeout_a: assert property (halt_set |=> OUT_HIZ && CLOCK_ERROR)
    else $error("Timeout did not halt the outputs.");
  halt_no_sample_a: assert property (OUT_HIZ |=> !SAMPLE_VALID)
    else $error("Sample delivered while halted.");
  ratio_flag_a: assert property (frame_evt && !first_reg && !ratio_ok |=> CLOCK_ERROR)
    else $error("Bad ratio not flagged.");
  recover_a: assert property (halt_clr && !halt_set |=> !OUT_HIZ ##0 !CLOCK_ERROR)
    else $error("Halt not lifted after good frames.");
  status_read_a: assert property (REG_RD && REG_ADDR == sap_pkg::ADDR_STATUS
      |=> REG_RDATA[sap_pkg::STAT_ERR_BIT] == $past(CLOCK_ERROR))
    else $error("Status read disagrees with error flag.");
  format_write_a: assert property (REG_WR && REG_ADDR == sap_pkg::ADDR_FORMAT
      |=> format_reg == $past(REG_WDATA))
    else $error("Format write lost.");
  format_hold_a: assert property (!(REG_WR && REG_ADDR == sap_pkg::ADDR_FORMAT) |=> $stable(format_reg))
    else $error("Format changed without a write.");
  offset_write_a: assert property (REG_WR && REG_ADDR == sap_pkg::ADDR_OFFSET_LOW
      |=> offset_low_reg == $past(REG_WDATA))
    else $error("Offset write lost.");
  mono_left_a: assert property (SAMPLE_VALID && $past(PARALLEL_OUTPUT_MODE)
      |-> SAMPLE_RIGHT == SAMPLE_LEFT)
    else $error("Mono output not taken from left.");
  tdm_start_a: assert property (@(posedge BIT_CLK) disable iff (SYS_RST)
      l_fmt == sap_pkg::FMT_TDM && rising |=> bit_cnt == 10'h001)
    else $error("TDM frame did not start at sync rise.");

  halt_seen_c: cover property (halt_set ##1 OUT_HIZ);
  recover_seen_c: cover property (halt_clr);
  ratio_bad_c: cover property (frame_evt && !first_reg && !ratio_ok);
  mono_seen_c: cover property (SAMPLE_VALID && PARALLEL_OUTPUT_MODE);

endmodule

// ### sap_host_model.sv
// Host model: drives bit clock, frame clock and serial data for bursts of frames.
// Assumes the bench chooses format, ratio, offset and samples for each burst.
`timescale 1ns/1ps
module sap_host_model (
  // Serial audio link
  output logic BIT_CLK,
  output logic FRAME_CLK,
  output logic SERIAL_DATA
);
  // The clocks stand still between bursts, which the port must see as a halt.
  initial begin
    BIT_CLK = 1'b0;
    FRAME_CLK = 1'b0;
    SERIAL_DATA = 1'b0;
  end

  // Data changes on falling edges so that it is settled at each rising edge.
  task automatic send(input int fmt, input int wl, input int ratio, input int off,
                      input logic [31:0] l, input logic [31:0] r, input int frames);
    int half;
    int st;
    int ch;
    int q;
    logic [31:0] w;
    half = (fmt == 3) ? 32 : ratio / 2;
    st = (fmt == 0) ? off + 1 : (fmt == 2) ? half - wl : off;
    FRAME_CLK = (fmt == 0); // Idle level makes bit 0 carry the frame start edge.
    #37;
    for (int f = 0; f < frames; f++) begin
      for (int i = 0; i < ratio; i++) begin
        BIT_CLK = 1'b0;
        if (fmt == 3) FRAME_CLK = (i == 0);
        else FRAME_CLK = (i < half) ^ (fmt == 0);
        ch = (fmt == 3) ? ((i - off) >= 32) : (i >= half);
        q = i - ch * half - st;
        w = (ch != 0) ? r : l;
        // Bits outside a word toggle, so nothing passes for data by accident.
        if (q >= 0 && q < wl && ch < 2 && i >= off) SERIAL_DATA = w[31 - q];
        else SERIAL_DATA = ~SERIAL_DATA;
        #80 BIT_CLK = 1'b1;
        #80;
      end
    end
    BIT_CLK = 1'b0;
  endtask
endmodule

// ### serial_audio_input_port_tb.sv
// Testbench of the serial audio input port: registers, all formats, halt,
// recovery, ratio error and mono mode, checked against a queue of samples.
// Assumes sap_pkg and the host model are compiled before this file.
`timescale 1ns/1ps
module serial_audio_input_port_tb;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        mono = 1'b0;
  logic        bit_clk, frame_clk, serial_data, sample_valid, out_hiz, clock_error;
  logic [7:0]  reg_rdata, rd;
  logic [31:0] sample_left, sample_right, l, r, mask;
  logic [1:0]  rate_class;
  logic [8:0]  off;
  logic [63:0] exp_q[$];
  int          n_errors = 0;
  int          num_checks = 0;
  int          n_valid = 0;
  int          v0, wl, cyc;
  // Format, word code, bits per frame, offset, mono, ratio legal.
  int          tab[5][6] = '{'{0, 2, 64, 0, 1, 1}, '{1, 0, 32, 0, 0, 1}, '{2, 1, 64, 0, 0, 1},
                             '{0, 2, 48, 0, 0, 0}, '{3, 3, 128, 1, 0, 1}};

  sap_host_model u_host (.BIT_CLK(bit_clk), .FRAME_CLK(frame_clk), .SERIAL_DATA(serial_data));

  // The halt timeout must outlast the longest frame-clock level, about 1016 cycles in TDM at 128 bits.
  serial_audio_input_port #(.HALT_CYCLES(1500), .RECOVER_FRAMES(2)) u_dut (
    .CLOCK(clock), .SYS_RST(sys_rst), .BIT_CLK(bit_clk), .FRAME_CLK(frame_clk),
    .SERIAL_DATA(serial_data), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .PARALLEL_OUTPUT_MODE(mono),
    .SAMPLE_LEFT(sample_left), .SAMPLE_RIGHT(sample_right), .SAMPLE_VALID(sample_valid),
    .OUT_HIZ(out_hiz), .CLOCK_ERROR(clock_error), .RATE_CLASS(rate_class));

  // The system clock runs at 50 MHz.
  initial forever #10 clock = ~clock;

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_smp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data is registered, so it is taken just after the edge that sees the strobe.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Each sample pulse is held against the samples of the current burst.
  always @(posedge clock) begin
    if (sample_valid === 1'b1) begin
      n_valid++;
      cmp_smp(sample_left, exp_q[$][63:32]);
      cmp_smp(sample_right, exp_q[$][31:0]);
    end
  end

  // A hang is cut short at 1.9 ms, over twice the length of a normal run of about 0.82 ms.
  initial begin
    #1_900_000;
    n_errors++;
    complete_run();
  end

  initial begin
    void'($urandom(37279));
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd_reg(sap_pkg::ADDR_FORMAT, rd);
    cmp_reg(rd, sap_pkg::FORMAT_RESET);
    rd_reg(sap_pkg::ADDR_OFFSET_LOW, rd);
    cmp_reg(rd, sap_pkg::OFFSET_RESET);
    wr_reg(sap_pkg::ADDR_STATUS, 8'hFC);
    rd_reg(sap_pkg::ADDR_STATUS, rd);
    cmp_reg({6'h00, rd[1:0]}, 8'h03);
    rd_reg(8'h50, rd);
    cmp_reg(rd, 8'h00);
    for (int b = 0; b < 5; b++) begin
      wl = 16 + 4 * tab[b][1] + 4 * (tab[b][1] == 3);
      off = 9'(tab[b][3]);
      l = $urandom();
      r = $urandom();
      mask = 32'hFFFF_FFFF << (32 - wl);
      exp_q.push_back({l & mask, (tab[b][4] != 0) ? l & mask : r & mask});
      // Short TDM sync pulses ask for code 01 in the sync field.
      wr_reg(sap_pkg::ADDR_FORMAT, {off[8], 1'b0, 2'(tab[b][0]), (tab[b][0] == 3) ? 2'h1 : 2'h0,
                                    2'(tab[b][1])});
      wr_reg(sap_pkg::ADDR_OFFSET_LOW, off[7:0]);
      mono <= (tab[b][4] != 0);
      rd_reg(sap_pkg::ADDR_OFFSET_LOW, rd);
      cmp_reg(rd, off[7:0]);
      v0 = n_valid;
      u_host.send(tab[b][0], wl, tab[b][2], tab[b][3], l, r, 6);
      cmp_reg({7'h00, n_valid > v0}, {7'h00, tab[b][5] != 0});
      cmp_reg({6'h00, out_hiz, clock_error}, (tab[b][5] != 0) ? 8'h00 : 8'h03);
      cyc = tab[b][2] * 8;
      if (tab[b][5] != 0) cmp_reg({6'h00, rate_class}, (cyc >= 1250) ? 8'h00 : (cyc >= 694) ? 8'h01 : 8'h02);
      // The clocks stay halted long enough to allow a rate change next.
      repeat (5000) @(posedge clock);
      cmp_reg({6'h00, out_hiz, clock_error}, 8'h03);
      rd_reg(sap_pkg::ADDR_STATUS, rd);
      cmp_reg({6'h00, rd[1:0]}, 8'h03);
      $display("burst %0d done", b);
    end
    complete_run();
  end
endmodule
